// File: verilog/crf_pkg.sv
// Package: constants and types for the CPU register and flag file
package crf_pkg;
  localparam int DATA_W   = 16;
  localparam int BYTE_W   = 8;
  localparam int NUM_REGS = 8;
  localparam int SEL_W    = 3;
  localparam logic [SEL_W-1:0] SP_INDEX = 3'h7;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
  // Flag bit positions
  localparam int FLAG_I = 7;
  localparam int FLAG_U6 = 6;
  localparam int FLAG_H = 5;
  localparam int FLAG_U4 = 4;
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h80;
  localparam int NIB_W = 4;
  localparam int BYTE_HALF_BIT = 3;
  localparam int WORD_HALF_BIT = 11;
  localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
  localparam logic [7:0] BCD_ADJ_LO = 8'h06;
  localparam logic [7:0] BCD_ADJ_HI = 8'h60;
  localparam logic [7:0] BCD_HI_LIMIT = 8'h99;

  // Register write width
  typedef enum logic [1:0] {
    CRF_WR_NONE,
    CRF_WR_WORD,
    CRF_WR_HIGH,
    CRF_WR_LOW
  } crf_wr_t;

  // Flag-file operations
  typedef enum logic [4:0] {
    CRF_OP_NONE,
    CRF_OP_ADD_B,
    CRF_OP_ADDX_B,
    CRF_OP_SUB_B,
    CRF_OP_SUBX_B,
    CRF_OP_CMP_B,
    CRF_OP_NEG_B,
    CRF_OP_ADD_W,
    CRF_OP_SUB_W,
    CRF_OP_CMP_W,
    CRF_OP_LOGIC_B,
    CRF_OP_SHIFT_B,
    CRF_OP_DAA,
    CRF_OP_DAS,
    CRF_OP_BIT_LD,
    CRF_OP_BIT_AND,
    CRF_OP_BIT_OR,
    CRF_OP_BIT_XOR,
    CRF_OP_LOAD_FLAGS,
    CRF_OP_AND_FLAGS,
    CRF_OP_OR_FLAGS,
    CRF_OP_XOR_FLAGS
  } crf_op_t;

  // Branch condition codes
  typedef enum logic [3:0] {
    CRF_CC_T, CRF_CC_F, CRF_CC_HI, CRF_CC_LS, CRF_CC_CC, CRF_CC_CS, CRF_CC_NE, CRF_CC_EQ,
    CRF_CC_VC, CRF_CC_VS, CRF_CC_PL, CRF_CC_MI, CRF_CC_GE, CRF_CC_LT, CRF_CC_GT, CRF_CC_LE
  } crf_cc_t;
endpackage

// File: verilog/crf_alu_flags.sv
// Combinational result and flag evaluation for one execute step
`timescale 1ns/1ps
module crf_alu_flags
  import crf_pkg::*;
(
  input  crf_pkg::crf_op_t op,
  input  logic [15:0] opa,
  input  logic [15:0] opb,
  input  logic [2:0]  bit_sel,
  input  logic        bit_invert,
  input  logic        shift_out,
  input  logic [7:0]  flags_in,
  output logic [15:0] result,
  output logic [7:0]  flags_out,
  output logic        result_valid
);
  import crf_pkg::*;

  function automatic logic [16:0] add_w(input logic [15:0] a, input logic [15:0] b, input logic ci);
    add_w = {1'b0, a} + {1'b0, b} + {16'h0000, ci};
  endfunction

  logic [16:0] sum;
  logic [4:0]  nib;
  logic [12:0] low12;
  logic [7:0]  adj;
  logic        bitv;
  logic        cin;
  always_comb begin
    result       = 16'h0000;
    flags_out    = flags_in;
    result_valid = 1'b0;
    sum          = 17'h0_0000;
    nib          = 5'h00;
    low12        = 13'h0000;
    adj          = 8'h00;
    cin          = flags_in[FLAG_C];
    bitv         = opa[bit_sel] ^ bit_invert;
    case (op)
      CRF_OP_ADD_B, CRF_OP_ADDX_B, CRF_OP_SUB_B, CRF_OP_SUBX_B, CRF_OP_CMP_B, CRF_OP_NEG_B: begin
        if (op == CRF_OP_ADD_B || op == CRF_OP_ADDX_B) begin
          sum = add_w({8'h00, opa[7:0]}, {8'h00, opb[7:0]}, (op == CRF_OP_ADDX_B) & cin);
          nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, (op == CRF_OP_ADDX_B) & cin};
        end else begin
          // Subtract as a plus inverted b plus one, or plus zero for SUBX with C set; borrow is the inverted carry
          sum = add_w({8'h00, (op == CRF_OP_NEG_B) ? 8'h00 : opa[7:0]}, {8'h00, ~opb[7:0]},
                      ~((op == CRF_OP_SUBX_B) & cin));
          nib = {1'b0, (op == CRF_OP_NEG_B) ? 4'h0 : opa[3:0]} + {1'b0, ~opb[3:0]}
              + {4'h0, ~((op == CRF_OP_SUBX_B) & cin)};
        end
        result = {8'h00, sum[7:0]};
        result_valid = (op != CRF_OP_CMP_B);
        flags_out[FLAG_H] = (op == CRF_OP_ADD_B || op == CRF_OP_ADDX_B) ? nib[NIB_W] : ~nib[NIB_W];
        flags_out[FLAG_N] = sum[7];
        flags_out[FLAG_Z] = (sum[7:0] == 8'h00);
        if (op == CRF_OP_ADD_B || op == CRF_OP_ADDX_B) begin
          flags_out[FLAG_V] = (opa[7] == opb[7]) && (sum[7] != opa[7]);
          flags_out[FLAG_C] = sum[BYTE_W];
        end else begin
          flags_out[FLAG_V] = (((op == CRF_OP_NEG_B) ? 1'b0 : opa[7]) != opb[7]) && (sum[7] == opb[7]);
          flags_out[FLAG_C] = ~sum[BYTE_W];
        end
      end
      CRF_OP_ADD_W, CRF_OP_SUB_W, CRF_OP_CMP_W: begin
        if (op == CRF_OP_ADD_W) begin
          sum   = add_w(opa, opb, 1'b0);
          low12 = {1'b0, opa[11:0]} + {1'b0, opb[11:0]};
        end else begin
          sum   = add_w(opa, ~opb, 1'b1);
          low12 = {1'b0, opa[11:0]} + {1'b0, ~opb[11:0]} + 13'h0001;
        end
        result = sum[15:0];
        result_valid = (op != CRF_OP_CMP_W);
        flags_out[FLAG_H] = (op == CRF_OP_ADD_W) ? low12[WORD_HALF_BIT+1] : ~low12[WORD_HALF_BIT+1];
        flags_out[FLAG_N] = sum[15];
        flags_out[FLAG_Z] = (sum[15:0] == 16'h0000);
        flags_out[FLAG_V] = (op == CRF_OP_ADD_W) ? ((opa[15] == opb[15]) && (sum[15] != opa[15]))
                                                 : ((opa[15] != opb[15]) && (sum[15] == opb[15]));
        flags_out[FLAG_C] = (op == CRF_OP_ADD_W) ? sum[DATA_W] : ~sum[DATA_W];
      end
      CRF_OP_LOGIC_B: begin
        result = {8'h00, opa[7:0]};
        result_valid = 1'b1;
        flags_out[FLAG_N] = opa[7];
        flags_out[FLAG_Z] = (opa[7:0] == 8'h00);
        flags_out[FLAG_V] = 1'b0;
      end
      CRF_OP_SHIFT_B: begin
        result = {8'h00, opa[7:0]};
        result_valid = 1'b1;
        flags_out[FLAG_N] = opa[7];
        flags_out[FLAG_Z] = (opa[7:0] == 8'h00);
        flags_out[FLAG_V] = 1'b0;
        flags_out[FLAG_C] = shift_out;
      end
      CRF_OP_DAA, CRF_OP_DAS: begin
        // Packed BCD: each nibble one digit, correction steered by H and C, and for DAA also by a low digit above 9 or a byte above 99
        if (flags_in[FLAG_H] || (opa[3:0] > BCD_MAX_DIGIT && op == CRF_OP_DAA)) begin
          adj = adj | BCD_ADJ_LO;
        end
        if (flags_in[FLAG_C] || (opa[7:0] > BCD_HI_LIMIT && op == CRF_OP_DAA)) begin
          adj = adj | BCD_ADJ_HI;
        end
        result = {8'h00, (op == CRF_OP_DAA) ? (opa[7:0] + adj) : (opa[7:0] - adj)};
        result_valid = 1'b1;
        flags_out[FLAG_N] = result[7];
        flags_out[FLAG_Z] = (result[7:0] == 8'h00);
        flags_out[FLAG_C] = ((adj & BCD_ADJ_HI) != 8'h00) | flags_in[FLAG_C];
      end
      CRF_OP_BIT_LD:  flags_out[FLAG_C] = bitv;
      CRF_OP_BIT_AND: flags_out[FLAG_C] = flags_in[FLAG_C] & bitv;
      CRF_OP_BIT_OR:  flags_out[FLAG_C] = flags_in[FLAG_C] | bitv;
      CRF_OP_BIT_XOR: flags_out[FLAG_C] = flags_in[FLAG_C] ^ bitv;
      CRF_OP_LOAD_FLAGS: flags_out = opb[7:0];
      CRF_OP_AND_FLAGS:  flags_out = flags_in & opb[7:0];
      CRF_OP_OR_FLAGS:   flags_out = flags_in | opb[7:0];
      CRF_OP_XOR_FLAGS:  flags_out = flags_in ^ opb[7:0];
      default: flags_out = flags_in;
    endcase
  end
endmodule

// File: verilog/crf_register_file.sv
// CPU general registers, program counter and condition flags
`timescale 1ns/1ps
module crf_register_file
  import crf_pkg::*;
#(
  parameter int NREGS = NUM_REGS
)(
  input  logic                   clk,
  input  logic                   rst_n,
  // Register read ports
  input  logic [SEL_W-1:0]       rd_a_sel,
  input  logic [SEL_W-1:0]       rd_b_sel,
  input  logic [SEL_W-1:0]       addr_sel,
  output logic [DATA_W-1:0]      rd_a_word,
  output logic [DATA_W-1:0]      rd_b_word,
  output logic [BYTE_W-1:0]      reg_high_byte,
  output logic [BYTE_W-1:0]      reg_low_byte,
  output logic [DATA_W-1:0]      mem_addr,
  output logic [DATA_W-1:0]      stack_pointer_reg,
  // Register write port
  input  crf_pkg::crf_wr_t       wr_kind,
  input  logic [SEL_W-1:0]       wr_sel,
  input  logic [DATA_W-1:0]      wr_data,
  input  logic                   alu_to_reg,
  // Stack pointer adjust, for push, pop, calls and exceptions
  input  logic                   sp_adjust,
  input  logic [DATA_W-1:0]      sp_delta,
  // Program counter
  input  logic                   pc_load,
  input  logic [DATA_W-1:0]      pc_value,
  input  logic                   pc_advance,
  input  logic                   vector_valid,
  input  logic [BYTE_W-1:0]      vector_even_byte,
  input  logic [BYTE_W-1:0]      vector_odd_byte,
  output logic                   vector_fetch,
  output logic [DATA_W-1:0]      vector_addr,
  output logic [DATA_W-1:0]      program_counter,
  output logic [DATA_W-1:0]      fetch_addr,
  // Flag file
  input  crf_pkg::crf_op_t       flag_op,
  input  logic [DATA_W-1:0]      flag_opb,
  input  logic [2:0]             bit_sel,
  input  logic                   bit_invert,
  input  logic                   shift_out,
  input  logic                   exception_start,
  input  logic                   flags_restore,
  input  logic [BYTE_W-1:0]      restore_even_byte,
  input  logic [BYTE_W-1:0]      restore_odd_byte,
  input  crf_pkg::crf_cc_t       branch_cond,
  output logic [BYTE_W-1:0]      condition_flags,
  output logic [DATA_W-1:0]      flags_push_word,
  output logic                   irq_masked,
  output logic                   branch_taken,
  output logic [DATA_W-1:0]      alu_result
);
  import crf_pkg::*;

  // Selects are three bits wide, so only eight registers can be served
  if (NREGS != NUM_REGS) begin : g_nregs_check
    $error("crf_register_file: NREGS must equal eight");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [NUM_REGS-1:0][DATA_W-1:0] regs;
    logic [DATA_W-1:0]               pc;
    logic [BYTE_W-1:0]               flags;
    logic                            in_reset_fetch;
    logic [DATA_W-1:0]               rd_a;
    logic [DATA_W-1:0]               rd_b;
    logic [BYTE_W-1:0]               hi;
    logic [BYTE_W-1:0]               lo;
    logic [DATA_W-1:0]               addr;
    logic                            taken;
    logic [DATA_W-1:0]               result;
  } crf_state_t;

  crf_state_t state_reg;
  crf_state_t state_next;

  logic [DATA_W-1:0] alu_res;
  logic [BYTE_W-1:0] alu_flags;
  logic              alu_valid;

  crf_alu_flags u_alu (
    .op           (flag_op),
    .opa          (state_reg.regs[rd_a_sel]),
    .opb          (flag_opb),
    .bit_sel      (bit_sel),
    .bit_invert   (bit_invert),
    .shift_out    (shift_out),
    .flags_in     (state_reg.flags),
    .result       (alu_res),
    .flags_out    (alu_flags),
    .result_valid (alu_valid)
  );

  function automatic logic [DATA_W-1:0] even_addr(input logic [DATA_W-1:0] a);
    even_addr = {a[DATA_W-1:1], 1'b0};
  endfunction

  function automatic logic cond_eval(input crf_cc_t cc, input logic [BYTE_W-1:0] f);
    logic n;
    logic z;
    logic v;
    logic c;
    n = f[FLAG_N];
    z = f[FLAG_Z];
    v = f[FLAG_V];
    c = f[FLAG_C];
    case (cc)
      CRF_CC_T:  cond_eval = 1'b1;
      CRF_CC_F:  cond_eval = 1'b0;
      CRF_CC_HI: cond_eval = ~(c | z);
      CRF_CC_LS: cond_eval = c | z;
      CRF_CC_CC: cond_eval = ~c;
      CRF_CC_CS: cond_eval = c;
      CRF_CC_NE: cond_eval = ~z;
      CRF_CC_EQ: cond_eval = z;
      CRF_CC_VC: cond_eval = ~v;
      CRF_CC_VS: cond_eval = v;
      CRF_CC_PL: cond_eval = ~n;
      CRF_CC_MI: cond_eval = n;
      CRF_CC_GE: cond_eval = ~(n ^ v);
      CRF_CC_LT: cond_eval = n ^ v;
      CRF_CC_GT: cond_eval = ~(z | (n ^ v));
      CRF_CC_LE: cond_eval = z | (n ^ v);
      default:   cond_eval = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_next = state_reg;
    // Register writes; byte writes leave the other half untouched
    case (wr_kind)
      CRF_WR_WORD: state_next.regs[wr_sel] = alu_to_reg ? alu_res : wr_data;
      CRF_WR_HIGH: state_next.regs[wr_sel][15:8] = alu_to_reg ? alu_res[7:0] : wr_data[7:0];
      CRF_WR_LOW:  state_next.regs[wr_sel][7:0] = alu_to_reg ? alu_res[7:0] : wr_data[7:0];
      default: ;
    endcase
    // Stack pointer adjust wins over a same-cycle write to register seven
    if (sp_adjust) begin
      state_next.regs[SP_INDEX] = state_reg.regs[SP_INDEX] + sp_delta;
    end
    // Program counter
    if (state_reg.in_reset_fetch) begin
      if (vector_valid) begin
        state_next.pc = even_addr({vector_even_byte, vector_odd_byte});
        state_next.in_reset_fetch = 1'b0;
      end
    end else if (pc_load) begin
      state_next.pc = even_addr(pc_value);
    end else if (pc_advance) begin
      state_next.pc = state_reg.pc + 16'h0002;
    end
    // Flags: restore, then operations, exception entry forces the mask last
    if (flags_restore) begin
      state_next.flags = restore_even_byte;
    end else if (alu_valid || flag_op != CRF_OP_NONE) begin
      state_next.flags = alu_flags;
    end
    if (exception_start) begin
      state_next.flags[FLAG_I] = 1'b1;
    end
    // Registered read and address outputs
    state_next.rd_a   = state_next.regs[rd_a_sel];
    state_next.rd_b   = state_next.regs[rd_b_sel];
    state_next.hi     = state_next.regs[rd_a_sel][15:8];
    state_next.lo     = state_next.regs[rd_a_sel][7:0];
    state_next.addr   = state_next.regs[addr_sel];
    state_next.taken  = cond_eval(branch_cond, state_next.flags);
    state_next.result = alu_res;
    // Synchronous reset: mask set, PC waits for vector, data left at zero
    if (!rst_n) begin
      state_next = '0;
      state_next.flags = FLAGS_RESET;
      state_next.in_reset_fetch = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rd_a_word         = state_reg.rd_a;
  assign rd_b_word         = state_reg.rd_b;
  assign reg_high_byte     = state_reg.hi;
  assign reg_low_byte      = state_reg.lo;
  assign mem_addr          = state_reg.addr;
  assign stack_pointer_reg = state_reg.regs[SP_INDEX];
  assign program_counter   = state_reg.pc;
  assign fetch_addr        = state_reg.pc;
  assign vector_fetch      = state_reg.in_reset_fetch;
  assign vector_addr       = RESET_VECTOR_ADDR;
  assign condition_flags   = state_reg.flags;
  assign flags_push_word   = {state_reg.flags, state_reg.flags};
  assign irq_masked        = state_reg.flags[FLAG_I];
  assign branch_taken      = state_reg.taken;
  assign alu_result        = state_reg.result;
endmodule

// File: test/crf_vector_source.sv
// Reset vector memory model that answers the vector fetch
`timescale 1ns/1ps
module crf_vector_source #(
  parameter logic [15:0] VEC_WORD = 16'h1235,
  parameter int          WAIT_CYC = 3
)(
  input  logic        clk,
  input  logic        rst_n,
  input  logic        vector_fetch,
  input  logic [15:0] vector_addr,
  output logic        vector_valid,
  output logic [7:0]  vector_even_byte,
  output logic [7:0]  vector_odd_byte
);
  int wait_cnt = 0;
  initial begin
    vector_valid = 1'b0;
    vector_even_byte = 8'h00;
    vector_odd_byte = 8'h00;
  end
  // Bytes toggle while not valid so a stale value never looks right
  always @(negedge clk) begin
    vector_even_byte <= ~vector_even_byte;
    vector_odd_byte <= ~vector_odd_byte;
    vector_valid <= 1'b0;
    wait_cnt <= 0;
    if (rst_n && vector_fetch && !vector_valid) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt == WAIT_CYC && vector_addr[15:1] == 15'h0000) begin
        vector_valid <= 1'b1;
        vector_even_byte <= VEC_WORD[15:8];
        vector_odd_byte <= VEC_WORD[7:0];
      end
    end
  end
endmodule

// File: test/crf_rf_monitor.sv
// Port-level assertions for the register and flag file
`timescale 1ns/1ps
module crf_rf_monitor
  import crf_pkg::*;
(
  input logic              clk,
  input logic              rst_n,
  input logic [SEL_W-1:0]  rd_a_sel,
  input logic [SEL_W-1:0]  addr_sel,
  input logic [SEL_W-1:0]  wr_sel,
  input crf_pkg::crf_wr_t  wr_kind,
  input logic [DATA_W-1:0] wr_data,
  input logic              alu_to_reg,
  input logic              sp_adjust,
  input logic [DATA_W-1:0] sp_delta,
  input logic              pc_load,
  input logic [DATA_W-1:0] pc_value,
  input logic              vector_valid,
  input logic [BYTE_W-1:0] vector_even_byte,
  input logic [BYTE_W-1:0] vector_odd_byte,
  input logic              vector_fetch,
  input crf_pkg::crf_op_t  flag_op,
  input logic              exception_start,
  input logic              flags_restore,
  input logic [BYTE_W-1:0] restore_even_byte,
  input logic [BYTE_W-1:0] reg_high_byte,
  input logic [DATA_W-1:0] mem_addr,
  input logic [DATA_W-1:0] stack_pointer_reg,
  input logic [DATA_W-1:0] program_counter,
  input logic [BYTE_W-1:0] condition_flags,
  input logic [DATA_W-1:0] flags_push_word,
  input logic              irq_masked
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic plain_wr;
  // A stack adjust overrides a write to the stack pointer
  assign plain_wr = !alu_to_reg && !(sp_adjust && wr_sel == SP_INDEX);
  ////////////////////////////////////////////////////////////////
  a_word_addr_full: assert property (
    wr_kind == CRF_WR_WORD && plain_wr && addr_sel == wr_sel |=> mem_addr == $past(wr_data))
    else $error("address output lost the written word");
  a_high_byte_wr: assert property (
    wr_kind == CRF_WR_HIGH && plain_wr && rd_a_sel == wr_sel |=> reg_high_byte == $past(wr_data[7:0]))
    else $error("high byte write not seen");
  a_sp_word_wr: assert property (
    wr_kind == CRF_WR_WORD && plain_wr && wr_sel == SP_INDEX |=> stack_pointer_reg == $past(wr_data))
    else $error("stack pointer missed word write");
  a_sp_adjust_sum: assert property (
    sp_adjust |=> stack_pointer_reg == $past(stack_pointer_reg) + $past(sp_delta))
    else $error("stack pointer adjust wrong");
  a_vector_pc_load: assert property (
    vector_fetch && vector_valid
    |=> !vector_fetch && program_counter == {$past(vector_even_byte), $past(vector_odd_byte[7:1]), 1'b0})
    else $error("vector word not taken into the program counter");
  a_pc_held_fetch: assert property (
    vector_fetch && !vector_valid |=> $stable(program_counter))
    else $error("program counter moved before the vector arrived");
  a_pc_load_even: assert property (
    !vector_fetch && pc_load |=> program_counter == {$past(pc_value[15:1]), 1'b0})
    else $error("program counter load not forced even");
  a_exc_mask_set: assert property (
    exception_start |=> condition_flags[FLAG_I] && irq_masked)
    else $error("mask bit not set on exception start");
  a_restore_even: assert property (
    flags_restore && !exception_start |=> condition_flags == $past(restore_even_byte))
    else $error("flag restore did not take the even byte");
  a_push_twin: assert property (
    flags_push_word == {condition_flags, condition_flags})
    else $error("pushed flag word is not two copies");
  a_flags_hold: assert property (
    flag_op == CRF_OP_NONE && !exception_start && !flags_restore |=> $stable(condition_flags))
    else $error("flags changed with no operation");
endmodule

bind crf_register_file crf_rf_monitor mon_u (.*);

// File: test/crf_register_file_tb.sv
// Self-checking bench for the register and flag file
`timescale 1ns/1ps
module crf_register_file_tb;
  import crf_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [2:0]        rd_a_sel, rd_b_sel, addr_sel, wr_sel, bit_sel;
  logic [15:0]       wr_data, sp_delta, pc_value, flag_opb, rd_a_word, rd_b_word, mem_addr, vector_addr;
  logic [15:0]       stack_pointer_reg, program_counter, fetch_addr, flags_push_word, alu_result;
  logic [7:0]        reg_high_byte, reg_low_byte, vector_even_byte, vector_odd_byte;
  logic [7:0]        restore_even_byte, restore_odd_byte, condition_flags;
  logic              alu_to_reg, sp_adjust, pc_load, pc_advance, vector_valid, vector_fetch, bit_invert;
  logic              shift_out, exception_start, flags_restore, irq_masked, branch_taken;
  crf_wr_t           wr_kind;
  crf_op_t           flag_op;
  crf_cc_t           branch_cond;
  int                bad_count = 0;
  int                samples_checked = 0;
  int                cycles = 0;

  crf_register_file dut_u (.*);
  crf_vector_source part_u (.clk(clk), .rst_n(rst_n), .vector_fetch(vector_fetch), .vector_addr(vector_addr),
    .vector_valid(vector_valid), .vector_even_byte(vector_even_byte), .vector_odd_byte(vector_odd_byte));

  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Generous ceiling; the sequence needs well under 200 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic idle;
    wr_kind = CRF_WR_NONE;
    alu_to_reg = 1'b0;
    sp_adjust = 1'b0;
    pc_load = 1'b0;
    pc_advance = 1'b0;
    flag_op = CRF_OP_NONE;
    exception_start = 1'b0;
    flags_restore = 1'b0;
  endtask
  // Pulses last exactly one rising edge, then drop at the falling edge
  task automatic step;
    @(negedge clk);
    idle();
  endtask
  task automatic wr(input crf_wr_t k, input logic [2:0] s, input logic [15:0] d);
    wr_kind = k;
    wr_sel = s;
    wr_data = d;
    step();
  endtask
  task automatic op(input crf_op_t o, input logic [15:0] a, input logic [15:0] b, input logic [7:0] fm,
                    input logic [7:0] fe, input logic [7:0] rm, input logic [7:0] re);
    wr(CRF_WR_WORD, 3'h0, a);
    rd_a_sel = 3'h0;
    flag_op = o;
    flag_opb = b;
    step();
    check("flags", {8'h00, condition_flags & fm}, {8'h00, fe});
    check("result", {8'h00, alu_result[7:0] & rm}, {8'h00, re});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    idle();
    {rd_a_sel, rd_b_sel, addr_sel, wr_sel, bit_sel, bit_invert, shift_out} = '0;
    {wr_data, sp_delta, pc_value, flag_opb, restore_even_byte, restore_odd_byte} = '0;
    branch_cond = CRF_CC_T;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    check("flags", {8'h00, condition_flags}, 16'h0080);
    check("fetch", {15'h0000, vector_fetch}, 16'h0001);
    check("vaddr", vector_addr, 16'h0000);
    pc_load = 1'b1;
    pc_value = 16'h4000;
    step();
    check("pc", program_counter, 16'h0000);
    for (int i = 0; i < 20 && vector_fetch !== 1'b0; i++) step();
    check("pc", program_counter, 16'h1234);
    check("fetch_addr", fetch_addr, 16'h1234);
    addr_sel = 3'h7;
    wr(CRF_WR_WORD, 3'h7, 16'hff80);
    check("sp", stack_pointer_reg, 16'hff80);
    check("addr", mem_addr, 16'hff80);
    sp_adjust = 1'b1;
    sp_delta = 16'hfffe;
    step();
    check("sp", stack_pointer_reg, 16'hff7e);
    rd_a_sel = 3'h2;
    addr_sel = 3'h2;
    wr(CRF_WR_WORD, 3'h2, 16'ha5c3);
    wr(CRF_WR_HIGH, 3'h2, 16'h0011);
    check("word", rd_a_word, 16'h11c3);
    check("addr", mem_addr, 16'h11c3);
    wr(CRF_WR_LOW, 3'h2, 16'h0022);
    check("low", {8'h00, reg_low_byte}, 16'h0022);
    check("high", {8'h00, reg_high_byte}, 16'h0011);
    pc_load = 1'b1;
    pc_value = 16'h4567;
    step();
    check("pc", program_counter, 16'h4566);
    pc_advance = 1'b1;
    step();
    check("pc", program_counter, 16'h4568);
    op(CRF_OP_LOAD_FLAGS, 16'h0000, 16'h0050, 8'hff, 8'h50, 8'h00, 8'h00);
    op(CRF_OP_ADD_B, 16'h0008, 16'h0008, 8'hff, 8'h70, 8'hff, 8'h10);
    op(CRF_OP_ADD_B, 16'h0080, 16'h0080, 8'hff, 8'h57, 8'hff, 8'h00);
    op(CRF_OP_ADDX_B, 16'h007f, 16'h0000, 8'hff, 8'h7a, 8'hff, 8'h80);
    op(CRF_OP_SUB_B, 16'h0010, 16'h0001, 8'hff, 8'h70, 8'hff, 8'h0f);
    op(CRF_OP_SUBX_B, 16'h0000, 16'h0001, 8'hff, 8'h79, 8'hff, 8'hff);
    op(CRF_OP_CMP_B, 16'h0005, 16'h0005, 8'hff, 8'h54, 8'h00, 8'h00);
    op(CRF_OP_NEG_B, 16'h0000, 16'h0001, 8'hff, 8'h79, 8'hff, 8'hff);
    op(CRF_OP_ADD_W, 16'h0800, 16'h0800, 8'hff, 8'h70, 8'hff, 8'h00);
    op(CRF_OP_SUB_W, 16'h1000, 16'h0001, 8'hff, 8'h70, 8'hff, 8'hff);
    op(CRF_OP_CMP_W, 16'h8000, 16'h0001, 8'hff, 8'h72, 8'h00, 8'h00);
    op(CRF_OP_LOGIC_B, 16'h0000, 16'h0000, 8'h0e, 8'h04, 8'hff, 8'h00);
    shift_out = 1'b1;
    op(CRF_OP_SHIFT_B, 16'h0080, 16'h0000, 8'h0f, 8'h09, 8'h00, 8'h00);
    op(CRF_OP_LOAD_FLAGS, 16'h0000, 16'h0000, 8'hff, 8'h00, 8'h00, 8'h00);
    op(CRF_OP_DAA, 16'h000a, 16'h0000, 8'h05, 8'h00, 8'hff, 8'h10);
    op(CRF_OP_LOAD_FLAGS, 16'h0000, 16'h0020, 8'hff, 8'h20, 8'h00, 8'h00);
    op(CRF_OP_DAA, 16'h0012, 16'h0000, 8'h05, 8'h00, 8'hff, 8'h18);
    op(CRF_OP_LOAD_FLAGS, 16'h0000, 16'h0020, 8'hff, 8'h20, 8'h00, 8'h00);
    op(CRF_OP_DAS, 16'h001c, 16'h0000, 8'h05, 8'h00, 8'hff, 8'h16);
    bit_sel = 3'h2;
    op(CRF_OP_BIT_LD, 16'h0004, 16'h0000, 8'h01, 8'h01, 8'h00, 8'h00);
    op(CRF_OP_BIT_AND, 16'h0004, 16'h0000, 8'h01, 8'h01, 8'h00, 8'h00);
    op(CRF_OP_BIT_XOR, 16'h0004, 16'h0000, 8'h01, 8'h00, 8'h00, 8'h00);
    bit_sel = 3'h7;
    bit_invert = 1'b1;
    op(CRF_OP_BIT_OR, 16'h0004, 16'h0000, 8'h01, 8'h01, 8'h00, 8'h00);
    op(CRF_OP_LOAD_FLAGS, 16'h0000, 16'h00ff, 8'hff, 8'hff, 8'h00, 8'h00);
    op(CRF_OP_AND_FLAGS, 16'h0000, 16'h000f, 8'hff, 8'h0f, 8'h00, 8'h00);
    op(CRF_OP_OR_FLAGS, 16'h0000, 16'h00d0, 8'hff, 8'hdf, 8'h00, 8'h00);
    op(CRF_OP_XOR_FLAGS, 16'h0000, 16'h00ff, 8'hff, 8'h20, 8'h00, 8'h00);
    exception_start = 1'b1;
    step();
    check("flags", {8'h00, condition_flags}, 16'h00a0);
    check("masked", {15'h0000, irq_masked}, 16'h0001);
    flags_restore = 1'b1;
    restore_even_byte = 8'h12;
    restore_odd_byte = 8'hed;
    step();
    check("push", flags_push_word, 16'h1212);
    flags_restore = 1'b1;
    exception_start = 1'b1;
    restore_even_byte = 8'h05;
    step();
    check("flags", {8'h00, condition_flags}, 16'h0085);
    wr(CRF_WR_WORD, 3'h0, 16'h0008);
    flag_op = CRF_OP_ADD_B;
    flag_opb = 16'h0008;
    wr_kind = CRF_WR_LOW;
    wr_sel = 3'h1;
    alu_to_reg = 1'b1;
    rd_b_sel = 3'h1;
    step();
    check("alu_wr", {8'h00, rd_b_word[7:0]}, 16'h0010);
    op(CRF_OP_LOAD_FLAGS, 16'h0000, 16'h0004, 8'hff, 8'h04, 8'h00, 8'h00);
    for (int i = 0; i < 16; i++) begin
      branch_cond = crf_cc_t'(i);
      step();
      check("branch", {15'h0000, branch_taken}, 16'h9599 >> i & 16'h0001);
    end
    give_verdict();
  end
endmodule
